// file: include/asc_pkg.sv
// constants for the sequence A control block: register map, fields, timing
// assumes a 32-bit AXI4-Lite register bus and one system clock
package asc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] SEQ_A_CONTROL_ADDR = 32'h4001C008;
  localparam logic [31:0] SEQ_A_STATUS_ADDR  = 32'h4001C0FC;
  localparam logic [31:0] CONTROL_RESET      = 32'h00000000;
  localparam logic [31:0] WRITE_MASK_CTRL    = 32'hFDF00FFF;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CHAN_COUNT   = 12;
  localparam int CHAN_LSB     = 0;
  localparam int SAMPLE_TIME_EXTENSION_LSB    = 20;
  localparam int SAMPLE_TIME_EXTENSION_W      = 5;
  localparam int LAUNCH_BIT   = 26;
  localparam int BURST_BIT    = 27;
  localparam int STEP_BIT     = 28;
  localparam int PRIO_BIT     = 29;
  localparam int MODE_BIT     = 30;
  localparam int ENABLE_BIT   = 31;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_FLAG_BIT    = 0;
  localparam int ST_ACTIVE_BIT  = 1;
  localparam int ST_PREEMPT_BIT = 2;
  localparam int ST_CHAN_LSB    = 4;
  localparam int ST_PTR_LSB     = 8;

  // ----------------------------------------------------------------
  // timing, in half converter clock periods
  // ----------------------------------------------------------------
  localparam logic [9:0] SAMPLE_HALVES_DEFAULT = 10'h00D;
  localparam logic [9:0] HALVES_PER_EXTRA      = 10'h002;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: src/asc_next_chan.sv
// finds the lowest enabled channel at or above a start index
// assumes the mask and index are stable within the cycle
`timescale 1ns/1ps
`default_nettype none
module asc_next_chan #(
  parameter int N = 12
) (
  input  wire logic [N-1:0] mask_in,
  input  wire logic [3:0]   from_in,
  output logic              found_out,
  output logic [3:0]        idx_out
);
  always_comb begin
    found_out = 1'b0;
    idx_out   = 4'h0;
    // scan downward so the lowest match is the last one kept
    for (int i = N - 1; i >= 0; i--) begin
      if (mask_in[i] && (4'(i) >= from_in)) begin
        found_out = 1'b1;
        idx_out   = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// file: src/asc_ctrl.sv
// sequence A control: register, sampling timer, burst, single step, priority
// assumes triggers and sequence B signals are synchronous to clk_in pulses
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl #(
  parameter int HALF_CLKS       = 1,
  parameter int CONVERT_PERIODS = 12
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        hw_trigger_a_in,
  input  wire logic        seq_b_trigger_in,
  input  wire logic        seq_b_enable_in,
  input  wire logic        seq_b_done_in,
  output logic             seq_b_start_out,
  output logic             adc_sample_out,
  output logic             adc_convert_out,
  output logic             adc_abort_out,
  output logic [3:0]       adc_channel_out,
  output logic             conv_done_out,
  output logic             seq_a_flag_out
);
  typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT, ASC_WAIT_B} asc_state_t;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  logic [11:0] chan_mask_reg;
  logic [4:0]  sample_time_extension_reg;
  logic        burst_reg;
  logic        step_one_channel_reg;
  logic        sequence_a_priority_reg;
  logic        mode_reg;
  logic        sequence_a_enable_reg;
  logic        launch_reg;

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic        aw_ready_reg;
  logic        w_ready_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        ar_ready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  asc_state_t  state_reg;
  logic [9:0]  cnt_reg;
  logic [3:0]  chan_reg;
  logic [3:0]  ptr_reg;
  logic        b_busy_reg;
  logic        pend_a_reg;
  logic        sample_reg;
  logic        convert_reg;
  logic        abort_reg;
  logic        b_start_reg;
  logic        done_reg;
  logic        flag_reg;

  logic        do_write;
  logic [31:0] strb_mask;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_merged;
  logic [31:0] status_word;
  logic        flag_clear;
  logic        flag_set;
  logic        a_trig;
  logic        a_go;
  logic        b_req;
  logic        a_active;
  logic        ptr_found;
  logic [3:0]  ptr_idx;
  logic        first_found;
  logic [3:0]  first_idx;
  logic        next_found;
  logic [3:0]  next_idx;
  logic [3:0]  start_idx;
  logic        start_ok;
  logic [9:0]  sample_len;
  logic [9:0]  convert_len;

  assign do_write    = !aw_ready_reg && !w_ready_reg && !bvalid_reg;
  assign strb_mask   = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                        {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign ctrl_word   = {sequence_a_enable_reg, mode_reg, sequence_a_priority_reg,
                        step_one_channel_reg, burst_reg, 1'b0, 1'b0,
                        sample_time_extension_reg, 8'h00, chan_mask_reg};
  assign ctrl_merged = (ctrl_word & ~strb_mask) | (w_data_reg & strb_mask);
  assign status_word = {20'h00000, ptr_reg, chan_reg, 1'b0,
                        (state_reg == ASC_WAIT_B), a_active, flag_reg};
  assign a_active    = (state_reg != ASC_IDLE);
  assign b_req       = seq_b_trigger_in && seq_b_enable_in;
  // burst owns the sequence, so no other A trigger is looked at
  assign a_trig      = sequence_a_enable_reg && !burst_reg
                       && (hw_trigger_a_in || launch_reg);
  assign a_go        = sequence_a_enable_reg && (a_trig || pend_a_reg || burst_reg);
  assign start_idx   = ptr_found ? ptr_idx : first_idx;
  assign start_ok    = ptr_found || first_found;
  assign sample_len  = 10'((asc_pkg::SAMPLE_HALVES_DEFAULT
                       + asc_pkg::HALVES_PER_EXTRA * 10'(sample_time_extension_reg))
                       * HALF_CLKS);
  assign convert_len = 10'(2 * CONVERT_PERIODS * HALF_CLKS);

  asc_next_chan #(.N(asc_pkg::CHAN_COUNT)) u_ptr (
    .mask_in   (chan_mask_reg),
    .from_in   (ptr_reg),
    .found_out (ptr_found),
    .idx_out   (ptr_idx)
  );
  asc_next_chan #(.N(asc_pkg::CHAN_COUNT)) u_first (
    .mask_in   (chan_mask_reg),
    .from_in   (4'h0),
    .found_out (first_found),
    .idx_out   (first_idx)
  );
  asc_next_chan #(.N(asc_pkg::CHAN_COUNT)) u_next (
    .mask_in   (chan_mask_reg),
    .from_in   (4'(chan_reg + 4'h1)),
    .found_out (next_found),
    .idx_out   (next_idx)
  );

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_ready_reg <= 1'b1;
      w_ready_reg  <= 1'b1;
      aw_addr_reg  <= 32'h00000000;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= asc_pkg::RESP_OKAY;
    end else begin
      if (aw_ready_reg && s_axi_awvalid_in) begin
        aw_ready_reg <= 1'b0;
        aw_addr_reg  <= s_axi_awaddr_in;
      end
      if (w_ready_reg && s_axi_wvalid_in) begin
        w_ready_reg <= 1'b0;
        w_data_reg  <= s_axi_wdata_in;
        w_strb_reg  <= s_axi_wstrb_in;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        if (aw_addr_reg == asc_pkg::SEQ_A_CONTROL_ADDR
            || aw_addr_reg == asc_pkg::SEQ_A_STATUS_ADDR) begin
          bresp_reg <= asc_pkg::RESP_OKAY;
        end else begin
          bresp_reg <= asc_pkg::RESP_SLVERR;
        end
      end
      if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg   <= 1'b0;
        aw_ready_reg <= 1'b1;
        w_ready_reg  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_mask_reg             <= asc_pkg::CONTROL_RESET[asc_pkg::CHAN_LSB +: asc_pkg::CHAN_COUNT];
      sample_time_extension_reg <= asc_pkg::CONTROL_RESET[asc_pkg::SAMPLE_TIME_EXTENSION_LSB +: asc_pkg::SAMPLE_TIME_EXTENSION_W];
      burst_reg                 <= 1'b0;
      step_one_channel_reg      <= 1'b0;
      sequence_a_priority_reg   <= 1'b0;
      mode_reg                  <= 1'b0;
      sequence_a_enable_reg     <= 1'b0;
      launch_reg                <= 1'b0;
    end else begin
      // the launch bit is never stored, only turned into one pulse
      launch_reg <= do_write && aw_addr_reg == asc_pkg::SEQ_A_CONTROL_ADDR
                    && w_strb_reg[3] && w_data_reg[asc_pkg::LAUNCH_BIT];
      if (do_write && aw_addr_reg == asc_pkg::SEQ_A_CONTROL_ADDR) begin
        chan_mask_reg             <= ctrl_merged[asc_pkg::CHAN_LSB +: asc_pkg::CHAN_COUNT];
        sample_time_extension_reg <= ctrl_merged[asc_pkg::SAMPLE_TIME_EXTENSION_LSB +: asc_pkg::SAMPLE_TIME_EXTENSION_W];
        burst_reg                 <= ctrl_merged[asc_pkg::BURST_BIT];
        step_one_channel_reg      <= ctrl_merged[asc_pkg::STEP_BIT];
        sequence_a_priority_reg   <= ctrl_merged[asc_pkg::PRIO_BIT];
        mode_reg                  <= ctrl_merged[asc_pkg::MODE_BIT];
        sequence_a_enable_reg     <= ctrl_merged[asc_pkg::ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ar_ready_reg <= 1'b1;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= asc_pkg::RESP_OKAY;
    end else begin
      if (ar_ready_reg && s_axi_arvalid_in) begin
        ar_ready_reg <= 1'b0;
        rvalid_reg   <= 1'b1;
        rresp_reg    <= asc_pkg::RESP_OKAY;
        if (s_axi_araddr_in == asc_pkg::SEQ_A_CONTROL_ADDR) begin
          // reserved bit 25 and the launch bit read as zero
          rdata_reg <= ctrl_word & asc_pkg::WRITE_MASK_CTRL & ~(32'h1 << asc_pkg::LAUNCH_BIT);
        end else if (s_axi_araddr_in == asc_pkg::SEQ_A_STATUS_ADDR) begin
          rdata_reg <= status_word;
        end else begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= asc_pkg::RESP_SLVERR;
        end
      end
      if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg   <= 1'b0;
        ar_ready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= ASC_IDLE;
      cnt_reg     <= 10'h000;
      chan_reg    <= 4'h0;
      ptr_reg     <= 4'h0;
      b_busy_reg  <= 1'b0;
      pend_a_reg  <= 1'b0;
      sample_reg  <= 1'b0;
      convert_reg <= 1'b0;
      abort_reg   <= 1'b0;
      b_start_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      abort_reg   <= 1'b0;
      b_start_reg <= 1'b0;
      done_reg    <= 1'b0;
      if (seq_b_done_in) begin
        b_busy_reg <= 1'b0;
      end
      case (state_reg)
        ASC_IDLE: begin
          if (b_req && !b_busy_reg) begin
            b_start_reg <= 1'b1;
            b_busy_reg  <= 1'b1;
            pend_a_reg  <= pend_a_reg || a_trig;
          end else if (a_go && start_ok && (!b_busy_reg || seq_b_done_in)) begin
            state_reg  <= ASC_SAMPLE;
            chan_reg   <= start_idx;
            cnt_reg    <= sample_len;
            sample_reg <= 1'b1;
            pend_a_reg <= 1'b0;
          end else if (a_trig) begin
            // an A trigger during a B sequence waits for B to finish
            pend_a_reg <= 1'b1;
          end
          if (!sequence_a_enable_reg) begin
            pend_a_reg <= 1'b0;
          end
        end
        ASC_SAMPLE, ASC_CONVERT: begin
          if (b_req && sequence_a_priority_reg && !b_busy_reg) begin
            // high priority: B takes over and the running conversion is dropped
            state_reg   <= ASC_WAIT_B;
            abort_reg   <= 1'b1;
            sample_reg  <= 1'b0;
            convert_reg <= 1'b0;
            b_start_reg <= 1'b1;
            b_busy_reg  <= 1'b1;
          end else if (cnt_reg > 10'h001) begin
            cnt_reg <= cnt_reg - 10'h001;
          end else if (state_reg == ASC_SAMPLE) begin
            state_reg   <= ASC_CONVERT;
            cnt_reg     <= convert_len;
            sample_reg  <= 1'b0;
            convert_reg <= 1'b1;
          end else begin
            done_reg    <= 1'b1;
            convert_reg <= 1'b0;
            ptr_reg     <= next_found ? next_idx : 4'h0;
            if (!sequence_a_enable_reg || step_one_channel_reg) begin
              state_reg <= ASC_IDLE;
            end else if (next_found) begin
              state_reg  <= ASC_SAMPLE;
              chan_reg   <= next_idx;
              cnt_reg    <= sample_len;
              sample_reg <= 1'b1;
            end else if (burst_reg && first_found) begin
              state_reg  <= ASC_SAMPLE;
              chan_reg   <= first_idx;
              cnt_reg    <= sample_len;
              sample_reg <= 1'b1;
            end else begin
              state_reg <= ASC_IDLE;
            end
          end
        end
        ASC_WAIT_B: begin
          if (seq_b_done_in) begin
            state_reg  <= ASC_SAMPLE;
            cnt_reg    <= sample_len;
            sample_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= ASC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequence A flag; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  assign flag_clear = do_write && aw_addr_reg == asc_pkg::SEQ_A_STATUS_ADDR
                      && w_strb_reg[0] && w_data_reg[asc_pkg::ST_FLAG_BIT];
  assign flag_set   = state_reg == ASC_CONVERT && cnt_reg <= 10'h001
                      && !(b_req && sequence_a_priority_reg && !b_busy_reg)
                      && (!mode_reg || !next_found);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  assign s_axi_awready_out = aw_ready_reg;
  assign s_axi_wready_out  = w_ready_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_arready_out = ar_ready_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign seq_b_start_out   = b_start_reg;
  assign adc_sample_out    = sample_reg;
  assign adc_convert_out   = convert_reg;
  assign adc_abort_out     = abort_reg;
  assign adc_channel_out   = chan_reg;
  assign conv_done_out     = done_reg;
  assign seq_a_flag_out    = flag_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [9:0] samp_run_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      samp_run_reg <= 10'h000;
    end else begin
      samp_run_reg <= sample_reg ? 10'(samp_run_reg + 10'h001) : 10'h000;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_launch_one_pulse: assert property (launch_reg |=> !launch_reg)
    else $error("launch pulse longer than one cycle");
  a_launch_reads_zero: assert property (rvalid_reg |-> !rdata_reg[asc_pkg::LAUNCH_BIT])
    else $error("launch bit read back as one");
  a_sample_length: assert property ($fell(sample_reg) && convert_reg
    |-> samp_run_reg == $past(sample_len))
    else $error("sampling phase length wrong");
  a_default_sample: assert property ($fell(sample_reg) && convert_reg
    && sample_time_extension_reg == 5'h00
    |-> samp_run_reg == 10'(asc_pkg::SAMPLE_HALVES_DEFAULT * HALF_CLKS))
    else $error("default sampling not 6.5 converter clocks");
  a_preempt_abort: assert property (a_active && b_req && sequence_a_priority_reg && !b_busy_reg
    |=> abort_reg && b_start_reg && state_reg == ASC_WAIT_B)
    else $error("B trigger did not preempt A");
  a_low_prio_drop: assert property (a_active && !sequence_a_priority_reg
    |=> !b_start_reg)
    else $error("B started during low priority A pass");
  a_resume_same_chan: assert property (state_reg == ASC_WAIT_B && seq_b_done_in
    |=> sample_reg && chan_reg == $past(chan_reg))
    else $error("A did not resample the abandoned channel");
  a_disabled_idle: assert property (state_reg == ASC_IDLE && !sequence_a_enable_reg
    |=> state_reg == ASC_IDLE)
    else $error("disabled sequence started");
  a_flag_every_conv: assert property (done_reg && !mode_reg |-> flag_reg)
    else $error("flag not set after conversion");
endmodule
`default_nettype wire

// file: sim/asc_seq_b_model.sv
// stand-in for sequence B on the converter core: answers a start with a done pulse
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module asc_seq_b_model #(
  parameter int DONE_DELAY = 30
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  output logic      done_out
);
  int cnt_reg;
  // a restart while busy is not expected; the count simply begins again
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg  <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_reg == 1);
      if (start_in) cnt_reg <= DONE_DELAY;
      else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
    end
  end
endmodule
`default_nettype wire

// file: sim/asc_ctrl_tb.sv
// self-checking bench for the sequence A control block
// assumes HALF_CLKS 1, so a default sample phase is 13 system clocks
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_tb;
  logic clk_in = 0, rst_in = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic hw_a = 0, b_trg = 0, b_done;
  logic [31:0] awa = '0, wd = '0, ara = '0, rdata;
  logic awr, wr_r, bv, arr, rv, b_start, smp, cvt, abrt, cdone, flag;
  logic [1:0] br, rr;
  logic [3:0] chan;
  int bad_count = 0, n_compared = 0, cyc = 0, n_bs = 0, n_ab = 0, n_cd = 0;
  localparam logic [31:0] CTRL = asc_pkg::SEQ_A_CONTROL_ADDR;
  localparam logic [31:0] STAT = asc_pkg::SEQ_A_STATUS_ADDR;
  always #20 clk_in = ~clk_in;
  asc_ctrl asc_ctrl_i (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rre), .hw_trigger_a_in(hw_a), .seq_b_trigger_in(b_trg),
    .seq_b_enable_in(1'b1), .seq_b_done_in(b_done), .seq_b_start_out(b_start),
    .adc_sample_out(smp), .adc_convert_out(cvt), .adc_abort_out(abrt),
    .adc_channel_out(chan), .conv_done_out(cdone), .seq_a_flag_out(flag));
  asc_seq_b_model asc_seq_b_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .start_in(b_start), .done_out(b_done));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc++;
    n_bs += (b_start === 1'b1);
    n_ab += (abrt === 1'b1);
    n_cd += (cdone === 1'b1);
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    while (!(ad && dd)) begin
      @(posedge clk_in);
      if (!ad && awr === 1'b1) begin ad = 1; awv <= 0; end
      if (!dd && wr_r === 1'b1) begin dd = 1; wv <= 0; end
    end
    // bready stays high between writes so two calls never assign it twice in one step
    do @(posedge clk_in); while (bv !== 1'b1);
    chk({30'h0, br}, {30'h0, asc_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a; arv <= 1; rre <= 1;
    do @(posedge clk_in); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk_in); while (rv !== 1'b1);
    d = rdata;
    r = rr;
  endtask
  task automatic pulse_a();
    hw_a <= 1;
    @(posedge clk_in);
    hw_a <= 0;
  endtask
  task automatic pulse_b();
    b_trg <= 1;
    @(posedge clk_in);
    b_trg <= 0;
  endtask
  // waits for a sample phase, returns its channel and length in clocks
  task automatic sample(output logic [3:0] c, output int n);
    while (smp !== 1'b1) @(posedge clk_in);
    c = chan;
    n = 0;
    while (smp === 1'b1) begin @(posedge clk_in); n++; end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] c;
    int n;
    repeat (20) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    rd(CTRL, d, r); chk(d, 32'h00000000);
    rd(32'h4001C000, d, r); chk({30'h0, r}, {30'h0, asc_pkg::RESP_SLVERR});
    $display("test reset done");
    // launch with bit 25 kept at zero and burst clear
    wr(CTRL, 32'h84000003);
    sample(c, n); chk({c, n[27:0]}, {4'h0, 28'd13});
    sample(c, n); chk({28'h0, c}, 32'h1);
    rd(CTRL, d, r); chk(d, 32'h80000003);
    chk({31'h0, flag}, 32'h1);
    repeat (60) @(posedge clk_in);
    $display("test launch done");
    wr(CTRL, 32'h80300001);
    pulse_a();
    sample(c, n); chk(n, 19);
    repeat (60) @(posedge clk_in);
    $display("test sample time done");
    wr(CTRL, 32'h00000001);
    pulse_a();
    repeat (20) @(posedge clk_in);
    chk({31'h0, smp}, 32'h0);
    $display("test disabled done");
    wr(CTRL, 32'h80000001);
    n_bs = 0;
    pulse_a();
    while (smp !== 1'b1) @(posedge clk_in);
    pulse_b();
    repeat (4) @(posedge clk_in);
    chk(n_bs, 0);
    repeat (60) @(posedge clk_in);
    $display("test low priority done");
    wr(CTRL, 32'hA0000001);
    n_bs = 0;
    n_ab = 0;
    pulse_a();
    while (smp !== 1'b1) @(posedge clk_in);
    pulse_b();
    repeat (3) @(posedge clk_in);
    chk({n_bs[15:0], n_ab[15:0]}, {16'd1, 16'd1});
    sample(c, n); chk({c, n[27:0]}, {4'h0, 28'd13});
    repeat (60) @(posedge clk_in);
    $display("test priority done");
    wr(CTRL, 32'h90000003);
    pulse_a();
    sample(c, n); chk({28'h0, c}, 32'h0);
    repeat (40) @(posedge clk_in);
    chk({30'h0, smp, cvt}, 32'h0);
    pulse_a();
    sample(c, n); chk({28'h0, c}, 32'h1);
    repeat (40) @(posedge clk_in);
    pulse_a();
    sample(c, n); chk({28'h0, c}, 32'h0);
    $display("test single step done");
    repeat (40) @(posedge clk_in);
    wr(CTRL, 32'h88000001);
    sample(c, n);
    sample(c, n);
    chk({c, n[27:0]}, {4'h0, 28'd13});
    n_cd = 0;
    pulse_a();
    wr(CTRL, 32'h80000001);
    repeat (80) @(posedge clk_in);
    chk({n_cd[29:0], smp, cvt}, 32'h4);
    $display("test burst done");
    wr(STAT, 32'h00000001);
    wr(CTRL, 32'hD0000003);
    pulse_a();
    sample(c, n);
    repeat (40) @(posedge clk_in);
    chk({27'h0, c, flag}, 32'h0);
    pulse_a();
    sample(c, n);
    repeat (100) @(posedge clk_in);
    chk({27'h0, c, flag}, 32'h3);
    wr(STAT, 32'h00000001);
    chk({31'h0, flag}, 32'h0);
    $display("test pass end flag done");
    report_and_stop();
  end
endmodule
`default_nettype wire
